/* hdl/asra_pkg.sv */
// How it works
// R01: link runs mode 3, clock idles high
// R02: launch on falling edge, capture on rising
// R03: works four-wire or three-wire
// R04: chip select tied low keeps working
// R05: command byte write only, reads unserviced
// R06: after any reset, expect command byte
// R07: host opens each transaction with command
// R08: address low six bits, bit six direction
// R09: command with top bit high ignored
// R10: write data length 8/16/24 per register
// R11: read data length 8/16/24/32 per register
// R12: after data phase, back to command
// R13: 64 ones on input reset whole device
// R14: chip select high aborts, keeps registers
// R15: host resets device after power-up
// R16: read-only 16-bit part code at 0x07
// R17: host reads part code to check link
// R18: channel 0 on, inputs zero/one, setup 0
// R19: buffers off, external reference selected
// R20: sinc5 plus sinc1 at 31.25 kSPS
// R21: continuous, internal oscillator, reference off
// R22: crc and status append off
// R23: reference enabled drives reference output pin
package asra_pkg;
    // register addresses
    localparam logic [5:0] ADDR_COMMAND = 6'h00;
    localparam logic [5:0] ADDR_ADC_MODE = 6'h01;
    localparam logic [5:0] ADDR_IF_MODE = 6'h02;
    localparam logic [5:0] ADDR_CONV_DATA = 6'h04;
    localparam logic [5:0] ADDR_PART_CODE = 6'h07;
    localparam logic [5:0] ADDR_CH0 = 6'h10;
    localparam logic [5:0] ADDR_SETUP0 = 6'h20;
    localparam logic [5:0] ADDR_FILTER0 = 6'h28;
    localparam logic [5:0] ADDR_OFFSET0 = 6'h30;
    localparam logic [5:0] ADDR_GAIN0 = 6'h38;

    // command byte fields
    localparam int CMD_INVALID_BIT = 7;
    localparam int CMD_READ_BIT = 6;
    localparam int CMD_ADDR_MSB = 5;

    // reset values
    localparam logic [7:0] COMMAND_RESET = 8'h00;
    localparam logic [15:0] ADC_MODE_RESET = 16'h2000;
    localparam logic [15:0] IF_MODE_RESET = 16'h0000;
    localparam logic [15:0] CH0_RESET = 16'h8001;
    localparam logic [15:0] SETUP0_RESET = 16'h1000;
    localparam logic [15:0] FILTER0_RESET = 16'h0500;
    localparam logic [23:0] OFFSET0_RESET = 24'h800000;
    localparam logic [23:0] GAIN0_RESET_NOMINAL = 24'h500000;
    // value is arbitrary, low nibble is don't-care
    localparam logic [15:0] PART_CODE_DEFAULT = 16'h4c60;

    // implemented bits, reserved bits read as zero
    localparam logic [15:0] ADC_MODE_MASK = 16'ha77c;
    localparam logic [15:0] IF_MODE_MASK = 16'h19ed;
    localparam logic [15:0] CH0_MASK = 16'hf3ff;
    localparam logic [15:0] SETUP0_MASK = 16'h1f30;
    localparam logic [15:0] FILTER0_MASK = 16'h8f7f;

    localparam int REF_EN_BIT = 15;
    localparam int DATA_STAT_BIT = 6;

    // data phase lengths in bits
    localparam logic [5:0] LEN_8 = 6'd8;
    localparam logic [5:0] LEN_16 = 6'd16;
    localparam logic [5:0] LEN_24 = 6'd24;
    localparam logic [5:0] LEN_32 = 6'd32;
    localparam logic [5:0] CMD_LAST_BIT = 6'd7;

    localparam logic [6:0] ONES_RESET_COUNT = 7'd64;

    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ = 2'b11
    } asra_phase_e;
endpackage

/* hdl/asra_top.sv */
`timescale 1ns/1ps
module asra_top #(
    parameter logic [23:0] GAIN0_RESET = asra_pkg::GAIN0_RESET_NOMINAL, // factory gain default
    parameter logic [15:0] PART_CODE = asra_pkg::PART_CODE_DEFAULT // value is arbitrary
) (
    input wire logic clk, // system clock, 50 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic sclk, // serial clock from host, idles high
    input wire logic csN, // chip select, active low, may be tied low
    input wire logic din, // serial data in
    output logic dout, // serial data out
    output logic doutEnable, // high while dout is driven
    output logic refOutEnable, // drive reference onto reference_output_pin
    output logic [15:0] channel0Config, // channel 0 word
    output logic [15:0] setup0Config, // setup 0 word
    output logic [15:0] filter0Config, // filter 0 word
    output logic [15:0] adcModeConfig, // adc mode word
    output logic [15:0] ifModeConfig, // interface mode word
    output logic [23:0] offset0Coef, // offset 0 coefficient
    output logic [23:0] gain0Coef // gain 0 coefficient
);
    import asra_pkg::*;

    function automatic logic [5:0] regLength(input logic [5:0] addr, input logic withStatus);
        unique case (addr)
            ADDR_ADC_MODE, ADDR_IF_MODE, ADDR_PART_CODE, ADDR_CH0, ADDR_SETUP0, ADDR_FILTER0: regLength = LEN_16;
            ADDR_OFFSET0, ADDR_GAIN0: regLength = LEN_24;
            ADDR_CONV_DATA: regLength = withStatus ? LEN_32 : LEN_24;
            default: regLength = LEN_8;
        endcase
    endfunction

    function automatic logic regWritable(input logic [5:0] addr);
        unique case (addr)
            ADDR_ADC_MODE, ADDR_IF_MODE, ADDR_CH0, ADDR_SETUP0, ADDR_FILTER0,
            ADDR_OFFSET0, ADDR_GAIN0: regWritable = 1'b1;
            default: regWritable = 1'b0;
        endcase
    endfunction

    // system-domain register file
    logic [15:0] adcModeQ;
    logic [15:0] ifModeQ;
    logic [15:0] ch0Q;
    logic [15:0] setup0Q;
    logic [15:0] filter0Q;
    logic [23:0] offset0Q;
    logic [23:0] gain0Q;
    logic linkHoldQ;
    logic [2:0] wrSyncQ;
    logic [2:0] fullSyncQ;
    logic wrPulse;
    logic fullPulse;

    // link-domain state
    asra_phase_e phaseQ;
    logic [5:0] bitCntQ;
    logic [5:0] lenQ;
    logic [5:0] addrQ;
    logic writeOkQ;
    logic [23:0] shiftQ;
    logic [31:0] readWordQ;
    logic [31:0] readWordD;
    logic [6:0] onesCntQ;
    logic [5:0] wrAddrQ;
    logic [23:0] wrDataQ;
    logic wrToggleQ;
    logic fullToggleQ;
    logic doutQ;
    logic doutEnableQ;
    logic [7:0] cmdByte;
    logic lastDataBit;
    logic fullResetHit;
    logic linkClear;

    // chip select high clears the frame at once, since sclk stands still then
    assign linkClear = csN | linkHoldQ; // see R03 R14
    assign cmdByte = {shiftQ[6:0], din};
    assign lastDataBit = (bitCntQ == lenQ - 6'd1);
    assign fullResetHit = (onesCntQ == ONES_RESET_COUNT - 7'd1) && din; // see R13

    // registers are quasi-static: the last write settles here long before the next command completes
    always_comb begin
        readWordD = 32'h0;
        unique case (cmdByte[CMD_ADDR_MSB:0])
            ADDR_ADC_MODE: readWordD = {adcModeQ, 16'h0};
            ADDR_IF_MODE: readWordD = {ifModeQ, 16'h0};
            ADDR_PART_CODE: readWordD = {PART_CODE, 16'h0}; // see R16
            ADDR_CH0: readWordD = {ch0Q, 16'h0};
            ADDR_SETUP0: readWordD = {setup0Q, 16'h0};
            ADDR_FILTER0: readWordD = {filter0Q, 16'h0};
            ADDR_OFFSET0: readWordD = {offset0Q, 8'h0};
            ADDR_GAIN0: readWordD = {gain0Q, 8'h0};
            // no converter behind this block, so conversion data and status read zero
            default: readWordD = 32'h0; // see R05
        endcase
    end

    // frame sequencer, captures on the rising edge
    always_ff @(posedge sclk or posedge linkClear) begin
        if (linkClear) begin
            phaseQ <= PH_CMD; // see R06
            bitCntQ <= 6'd0;
            lenQ <= LEN_8;
            addrQ <= ADDR_COMMAND;
            writeOkQ <= 1'b0;
            shiftQ <= 24'h0;
            readWordQ <= 32'h0;
        end else begin
            shiftQ <= {shiftQ[22:0], din}; // see R01 R02
            if (fullResetHit) begin
                phaseQ <= PH_CMD; // see R13
                bitCntQ <= 6'd0;
            end else begin
                unique case (phaseQ)
                    PH_CMD: begin
                        if (bitCntQ == CMD_LAST_BIT) begin
                            bitCntQ <= 6'd0;
                            if (!cmdByte[CMD_INVALID_BIT]) begin // see R09
                                addrQ <= cmdByte[CMD_ADDR_MSB:0]; // see R08
                                lenQ <= regLength(cmdByte[CMD_ADDR_MSB:0], ifModeQ[DATA_STAT_BIT]); // see R10
                                writeOkQ <= regWritable(cmdByte[CMD_ADDR_MSB:0]);
                                readWordQ <= readWordD; // see R11
                                phaseQ <= cmdByte[CMD_READ_BIT] ? PH_READ : PH_WRITE; // see R08
                            end
                        end else begin
                            bitCntQ <= bitCntQ + 6'd1;
                        end
                    end
                    PH_WRITE, PH_READ: begin
                        if (lastDataBit) begin
                            phaseQ <= PH_CMD; // see R12
                            bitCntQ <= 6'd0;
                        end else begin
                            bitCntQ <= bitCntQ + 6'd1;
                        end
                    end
                endcase
            end
        end
    end

    // run of ones on din, counted across frames so a three-wire host can resync
    always_ff @(posedge sclk or posedge linkClear) begin
        if (linkClear) begin
            onesCntQ <= 7'd0;
        end else if (!din) begin
            onesCntQ <= 7'd0;
        end else if (onesCntQ != ONES_RESET_COUNT) begin
            onesCntQ <= onesCntQ + 7'd1; // see R13
        end
    end

    // write holding word outlives chip select so the crossing can still read it
    always_ff @(posedge sclk or posedge linkHoldQ) begin
        if (linkHoldQ) begin
            wrAddrQ <= ADDR_COMMAND;
            wrDataQ <= 24'h0;
            wrToggleQ <= 1'b0;
        end else if (!fullResetHit && phaseQ == PH_WRITE && lastDataBit && writeOkQ) begin
            wrAddrQ <= addrQ;
            wrDataQ <= {shiftQ[22:0], din}; // see R10
            wrToggleQ <= ~wrToggleQ;
        end
    end

    always_ff @(posedge sclk or posedge linkHoldQ) begin
        if (linkHoldQ) begin
            fullToggleQ <= 1'b0;
        end else if (fullResetHit) begin
            fullToggleQ <= ~fullToggleQ; // see R13
        end
    end

    // launch on the falling edge, msb first
    always_ff @(negedge sclk or posedge linkClear) begin
        if (linkClear) begin
            doutQ <= 1'b0;
            doutEnableQ <= 1'b0;
        end else begin
            doutEnableQ <= 1'b1; // see R04
            doutQ <= (phaseQ == PH_READ) ? readWordQ[5'd31 - bitCntQ[4:0]] : 1'b0; // see R02
        end
    end

    assign dout = doutQ;
    assign doutEnable = doutEnableQ;

    // system domain
    always_ff @(posedge clk) begin
        linkHoldQ <= rst;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrSyncQ <= 3'b000;
            fullSyncQ <= 3'b000;
        end else begin
            wrSyncQ <= {wrSyncQ[1:0], wrToggleQ};
            fullSyncQ <= {fullSyncQ[1:0], fullToggleQ};
        end
    end

    assign wrPulse = wrSyncQ[2] ^ wrSyncQ[1];
    assign fullPulse = fullSyncQ[2] ^ fullSyncQ[1];

    // a full reset restores defaults; chip select alone never reaches here
    always_ff @(posedge clk) begin
        if (rst || fullPulse) begin // see R13
            adcModeQ <= ADC_MODE_RESET; // see R21
            ifModeQ <= IF_MODE_RESET; // see R22
            ch0Q <= CH0_RESET; // see R18
            setup0Q <= SETUP0_RESET; // see R19
            filter0Q <= FILTER0_RESET; // see R20
            offset0Q <= OFFSET0_RESET;
            gain0Q <= GAIN0_RESET;
        end else if (wrPulse) begin
            unique case (wrAddrQ)
                ADDR_ADC_MODE: adcModeQ <= wrDataQ[15:0] & ADC_MODE_MASK;
                ADDR_IF_MODE: ifModeQ <= wrDataQ[15:0] & IF_MODE_MASK;
                ADDR_CH0: ch0Q <= wrDataQ[15:0] & CH0_MASK;
                ADDR_SETUP0: setup0Q <= wrDataQ[15:0] & SETUP0_MASK;
                ADDR_FILTER0: filter0Q <= wrDataQ[15:0] & FILTER0_MASK;
                ADDR_OFFSET0: offset0Q <= wrDataQ;
                ADDR_GAIN0: gain0Q <= wrDataQ;
                default: ;
            endcase
        end
    end

    assign refOutEnable = adcModeQ[REF_EN_BIT]; // see R23
    assign channel0Config = ch0Q;
    assign setup0Config = setup0Q;
    assign filter0Config = filter0Q;
    assign adcModeConfig = adcModeQ;
    assign ifModeConfig = ifModeQ;
    assign offset0Coef = offset0Q;
    assign gain0Coef = gain0Q;
endmodule // asra_top

/* verif/asra_host_model.sv */
`timescale 1ns/1ps
module asra_host_model (
    output logic sclk = 1'b1, // serial clock, idles high
    output logic csN = 1'b0, // chip select, low at start so the reset hold clears the link
    output logic din = 1'b1, // data to device
    input wire logic dout // data from device
);
    logic threeWire = 1'b0;
    // a short n aborts mid-word when threeWire is low; in three-wire mode csN stays low and nothing aborts
    task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
        rx = 64'h0;
        csN = 1'b0;
        #100;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            din = tx[i];
            #80;
            sclk = 1'b1;
            rx = {rx[62:0], dout};
            #80;
        end
        din = ~din;
        #100;
        csN = ~threeWire;
        #3000;
    endtask
endmodule // asra_host_model

/* verif/asra_top_asserts.sv */
`timescale 1ns/1ps
module asra_top_asserts
    import asra_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic csN, // chip select
    input wire logic doutEnable, // out drive
    input wire logic refOutEnable, // ref drive
    input wire logic [15:0] channel0Config, // ch0
    input wire logic [15:0] setup0Config, // setup0
    input wire logic [15:0] filter0Config, // filter0
    input wire logic [15:0] adcModeConfig, // adc mode
    input wire logic [15:0] ifModeConfig // if mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ch0Def; $fell(rst) |-> channel0Config == CH0_RESET; endproperty
    a_ch0Def: assert property (p_ch0Def) else $error("ch0 default");
    property p_setupDef; $fell(rst) |-> setup0Config == SETUP0_RESET; endproperty
    a_setupDef: assert property (p_setupDef) else $error("setup default");
    property p_filterDef; $fell(rst) |-> filter0Config == FILTER0_RESET; endproperty
    a_filterDef: assert property (p_filterDef) else $error("filter default");
    property p_adcDef; $fell(rst) |-> adcModeConfig == ADC_MODE_RESET; endproperty
    a_adcDef: assert property (p_adcDef) else $error("adc default");
    property p_ifDef; $fell(rst) |-> ifModeConfig == IF_MODE_RESET; endproperty
    a_ifDef: assert property (p_ifDef) else $error("if default");
    property p_reference_output_pin; refOutEnable == adcModeConfig[REF_EN_BIT]; endproperty
    a_reference_output_pin: assert property (p_reference_output_pin) else $error("ref drive");
    property p_csIdle; csN && $past(csN) |-> !doutEnable; endproperty
    a_csIdle: assert property (p_csIdle) else $error("out driven");
    // registers must survive an aborted frame
    property p_csKeep; csN [*8] |=> $stable(adcModeConfig) && $stable(channel0Config); endproperty
    a_csKeep: assert property (p_csKeep) else $error("regs moved");
endmodule // asra_top_asserts
bind asra_top asra_top_asserts i_asserts (.clk(clk), .rst(rst), .csN(csN), .doutEnable(doutEnable),
    .refOutEnable(refOutEnable), .channel0Config(channel0Config), .setup0Config(setup0Config),
    .filter0Config(filter0Config), .adcModeConfig(adcModeConfig), .ifModeConfig(ifModeConfig));

/* verif/tb_adc_serial_register_access.sv */
`timescale 1ns/1ps
module tb_adc_serial_register_access;
    import asra_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sclk, csN, din, dout, refOutEnable;
    logic [15:0] ch0, setup0, filter0, adcMode, ifMode;
    logic [23:0] offset0, gain0;
    logic [63:0] rx;
    logic [23:0] exp [int];
    logic [23:0] msk [int] = '{1: ADC_MODE_MASK, 2: IF_MODE_MASK, 'h10: CH0_MASK, 'h20: SETUP0_MASK,
        'h28: FILTER0_MASK, 'h30: '1, 'h38: '1};
    int fails = 0, comparisons = 0, seed = 88234, cycles = 0, len;
    int addrs [10] = '{1, 2, 7, 'h10, 'h20, 'h28, 'h30, 'h38, 0, 'h3f};
    asra_top i_dut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .din(din), .dout(dout), .doutEnable(),
        .refOutEnable(refOutEnable), .channel0Config(ch0), .setup0Config(setup0), .filter0Config(filter0),
        .adcModeConfig(adcMode), .ifModeConfig(ifMode), .offset0Coef(offset0), .gain0Coef(gain0));
    asra_host_model i_host (.sclk(sclk), .csN(csN), .din(din), .dout(dout));
    initial forever #10 clk = ~clk;
    always @(posedge clk)
        if (++cycles == 40000)
            results(1);
    task automatic results(int late);
        fails += late;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string what, logic [23:0] e, logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic defaults();
        exp = '{1: ADC_MODE_RESET, 2: IF_MODE_RESET, 'h10: CH0_RESET, 'h20: SETUP0_RESET,
            'h28: FILTER0_RESET, 'h30: OFFSET0_RESET, 'h38: GAIN0_RESET_NOMINAL};
    endtask
    task automatic chkPorts();
        logic [23:0] got [int];
        got = '{1: adcMode, 2: ifMode, 'h10: ch0, 'h20: setup0, 'h28: filter0, 'h30: offset0, 'h38: gain0};
        foreach (got[a])
            chk($sformatf("reg %0h", a), exp[a], got[a]);
        chk("reference_output_pin", {23'h0, exp[1][REF_EN_BIT]}, {23'h0, refOutEnable});
    endtask
    // write then read back in one frame, commands back to back
    task automatic wrRd(int a, logic [23:0] d);
        int n;
        logic [23:0] m;
        logic [23:0] e;
        n = !exp.exists(a) && a != 7 ? 8 : a >= 'h30 ? 24 : 16;
        m = 24'((1 << n) - 1) & (a == 7 ? 24'hfff0 : 24'hffffff);
        d = d & 24'((1 << n) - 1);
        if (exp.exists(a))
            exp[a] = d & msk[a];
        e = exp.exists(a) ? exp[a] : (a == 7 ? 24'(PART_CODE_DEFAULT) : 24'h0);
        i_host.frame(16 + 2 * n, (((64'(a) << n) | 64'(d)) << (8 + n)) | (64'(a + 'h40) << n), rx);
        chk("readback", e & m, rx[23:0] & m);
        chkPorts();
    endtask
    task automatic doReset();
        @(negedge clk) rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        defaults();
        repeat (4) @(negedge clk);
        chkPorts();
    endtask
    initial begin
        doReset();
        i_host.frame(64, '1, rx);
        chkPorts();
        for (int p = 0; p < 2; p++) begin
            foreach (addrs[i])
                wrRd(addrs[i], 24'($random(seed)));
            // status append on the second pass stretches the data read to 32 bits
            wrRd(2, {17'h0, p[0], 6'h0});
            len = exp[2][DATA_STAT_BIT] ? 32 : 24;
            i_host.frame(8 + len, 64'h44 << len, rx);
            chk("convData", 24'h0, rx[23:0]);
            i_host.frame(32, 64'h8101a5a4, rx);
            exp[1] = 24'h00a5a4 & msk[1];
            chkPorts();
            if (p == 0) begin
                i_host.frame(20, 64'h01fff, rx);
                chkPorts();
            end
            i_host.threeWire = 1'b1;
        end
        i_host.frame(64, '1, rx);
        defaults();
        chkPorts();
        wrRd(1, 24'($random(seed)));
        doReset();
        wrRd(7, 24'h0);
        results(0);
    end
endmodule // tb_adc_serial_register_access
